// *** eqs_consts.svh ***
// Constants for the egress queue scheduler and shaper.
// Assumes a 200 MHz core clock; rates are in kbps or Mbps units.
`ifndef EQS_CONSTS_SVH
`define EQS_CONSTS_SVH
`define EQS_NQ 8
`define EQS_W_DEF 7'h11
`define EQS_W_MIN 7'h01
`define EQS_W_MAX 7'h64
`define EQS_RATE_DEF 20'h0_01F4
`define EQS_KBPS_MIN 20'h0_0064
`define EQS_KBPS_MAX 20'hF_4240
`define EQS_MBPS_MIN 20'h0_0001
`define EQS_MBPS_MAX 20'h0_0CE4
`define EQS_CLK_MHZ 200
`define EQS_TICK_NS 5
`define EQS_TICK_CYC (1000 / (`EQS_CLK_MHZ * `EQS_TICK_NS))
`define EQS_BKT_CAP 32'sh0010_0000
`define EQS_MBPS_SCALE 32'h0000_03E8
`endif

// *** eqs_pkg.sv ***
// Types shared by the egress queue scheduler and shaper.
// Assumes nothing beyond the constants header.
package eqs_pkg;
  typedef enum logic [1:0] {
    EQS_STRICT = 2'b01,
    EQS_WT = 2'b10
  } eqs_mode_t;
  typedef struct packed {
    logic [31:0] data;
    logic [2:0] queue;
    logic last;
  } eqs_word_t;
  typedef struct packed {
    logic en;
    logic mbps;
    logic [19:0] rate;
  } eqs_shp_t;
endpackage

// *** eqs_fifo.sv ***
// Parameterised flip-flop FIFO with valid and ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module eqs_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// *** eqs_sched.sv ***
// Egress scheduler for one port: eight queues, strict or weighted, with shapers.
// Assumes the fabric offers one word per queue and the MAC pulls from the FIFO.
`timescale 1ns/1ps
`include "eqs_consts.svh"
// Behaviour
// RL1 - Strict mode sends highest non-empty queue first
// RL2 - Lower queues wait while highest holds frames
// RL3 - Per-port mode selects strict or weighted
// RL4 - Weighted mode rotates, share follows weight
// RL5 - Weights only matter under congestion
// RL6 - Weight defaults 17, accepts 1 to 100
// RL7 - Report each weight as port percentage
// RL8 - Independent shaper enable per queue
// RL9 - Queue rate default 500, unit-limited range
// RL10 - Excess lets queue exceed its rate
// RL11 - Per-port enable for aggregate shaper
// RL12 - Port rate default 500, unit-limited range
// RL13 - Port unit kbps or Mbps, kbps default
// RL14 - Enabled port shaper caps total traffic
// RL15 - Agent keeps port rate below line rate
// RL16 - Report disabled or rate per queue
// RL17 - Expose mode and per-queue weight readout
// RL18 - Reset: strict, shapers off, weights default
// RL19 - Token buckets; send only when non-negative
module eqs_sched
  import eqs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [`EQS_NQ-1:0][31:0] q_data,
  input wire logic [`EQS_NQ-1:0] q_last,
  input wire logic [`EQS_NQ-1:0] q_valid,
  output logic [`EQS_NQ-1:0] q_ready,
  output eqs_word_t tx_word,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic cfg_we,
  input wire logic cfg_weighted,
  input wire logic [`EQS_NQ-1:0][6:0] cfg_weight,
  input wire eqs_shp_t [`EQS_NQ-1:0] cfg_qshp,
  input wire logic [`EQS_NQ-1:0] cfg_excess,
  input wire eqs_shp_t cfg_pshp,
  output eqs_mode_t sts_mode,
  output logic [`EQS_NQ-1:0][6:0] sts_weight,
  output logic [`EQS_NQ-1:0][6:0] sts_percent,
  output eqs_shp_t [`EQS_NQ-1:0] sts_qshp,
  output eqs_shp_t sts_pshp
);
  function automatic logic rate_ok(input eqs_shp_t s);
    if (s.mbps) begin
      rate_ok = s.rate >= `EQS_MBPS_MIN && s.rate <= `EQS_MBPS_MAX;
    end else begin
      rate_ok = s.rate >= `EQS_KBPS_MIN && s.rate <= `EQS_KBPS_MAX;
    end
  endfunction
  // Credit per cycle in bits scaled by 1000: kbps gives rate, Mbps gives rate*1000.
  function automatic logic signed [31:0] credit(input eqs_shp_t s);
    credit = s.mbps ? $signed(32'(s.rate) * `EQS_MBPS_SCALE) : $signed(32'(s.rate));
  endfunction
  // Bucket refill step with a ceiling; cost of one 32-bit word is 128 bits at 200 MHz.
  function automatic logic signed [31:0] refill(input logic signed [31:0] b,
      input logic signed [31:0] c, input logic signed [31:0] cost);
    logic signed [31:0] n;
    n = b + c - cost;
    refill = (n > `EQS_BKT_CAP) ? `EQS_BKT_CAP : n;
  endfunction
  localparam logic signed [31:0] WORD_COST = 32'sh0001_F400;

  eqs_mode_t mode_q;
  logic [`EQS_NQ-1:0][6:0] wt_q;
  eqs_shp_t [`EQS_NQ-1:0] qshp_q;
  logic [`EQS_NQ-1:0] exc_q;
  eqs_shp_t pshp_q;
  logic [`EQS_NQ-1:0][6:0] pct_q;
  logic signed [31:0] qbkt_q [`EQS_NQ];
  logic signed [31:0] pbkt_q;
  logic [`EQS_NQ-1:0][7:0] dcnt_q;
  logic [2:0] rr_q;
  logic lock_q;
  logic [2:0] cur_q;
  logic [9:0] wsum;
  logic [`EQS_NQ-1:0] q_in_rate;
  logic [`EQS_NQ-1:0] elig;
  logic [`EQS_NQ-1:0] elig_cr;
  logic [2:0] strict_pick;
  logic [2:0] rr_pick;
  logic rr_found;
  logic fifo_in_ready;
  logic fifo_out_valid;
  eqs_word_t fifo_out;
  eqs_word_t word_d;
  logic [2:0] pick;
  logic pick_ok;

  wire port_ok = !pshp_q.en || pbkt_q >= 0; // RL14
  always_comb begin
    wsum = '0;
    for (int i = 0; i < `EQS_NQ; i++) begin
      wsum = wsum + 10'(wt_q[i]);
      q_in_rate[i] = !qshp_q[i].en || qbkt_q[i] >= 0 || exc_q[i]; // RL8 RL10 RL19
    end
  end
  assign elig = q_valid & q_in_rate & {`EQS_NQ{port_ok}};
  always_comb begin
    strict_pick = '0;
    for (int i = 0; i < `EQS_NQ; i++) begin
      if (elig[i]) strict_pick = 3'(i); // RL1 RL2
    end
  end
  // Weighted: queues with deficit credit go first; if none hold credit,
  // any waiting queue may send so that an uncongested port is not throttled.
  always_comb begin
    rr_pick = rr_q;
    rr_found = 1'b0;
    for (int i = 0; i < `EQS_NQ; i++) begin
      elig_cr[i] = elig[i] && dcnt_q[i] != 8'h00;
    end
    for (int k = `EQS_NQ - 1; k >= 0; k--) begin
      if (elig_cr[3'(rr_q + 3'(k))]) begin
        rr_pick = 3'(rr_q + 3'(k)); // RL4
        rr_found = 1'b1;
      end
    end
    if (!rr_found) begin
      for (int k = `EQS_NQ - 1; k >= 0; k--) begin
        if (elig[3'(rr_q + 3'(k))]) rr_pick = 3'(rr_q + 3'(k)); // RL5
      end
    end
  end
  // A frame in progress keeps its queue until its last word.
  assign pick = lock_q ? cur_q : (mode_q == EQS_WT ? rr_pick : strict_pick); // RL3
  assign pick_ok = lock_q ? q_valid[cur_q] : (elig != '0);
  wire send = pick_ok && fifo_in_ready;
  always_comb begin
    q_ready = '0;
    q_ready[pick] = send;
    word_d.data = q_data[pick];
    word_d.queue = pick;
    word_d.last = q_last[pick];
  end

  eqs_fifo #(.WIDTH($bits(eqs_word_t)), .DEPTH(16)) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_data(word_d),
    .in_valid(send),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(!tx_valid || tx_ready)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_word <= '0;
    end else if (!tx_valid || tx_ready) begin
      tx_valid <= fifo_out_valid;
      tx_word <= fifo_out;
    end
  end

  // Configuration: out-of-range values are refused and the old value kept.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= EQS_STRICT; // RL18
      for (int i = 0; i < `EQS_NQ; i++) begin
        wt_q[i] <= `EQS_W_DEF; // RL6 RL18
        qshp_q[i] <= {1'b0, 1'b0, `EQS_RATE_DEF}; // RL9 RL18
      end
      exc_q <= '0;
      pshp_q <= {1'b0, 1'b0, `EQS_RATE_DEF}; // RL12 RL13 RL18
    end else if (cfg_we) begin
      mode_q <= cfg_weighted ? EQS_WT : EQS_STRICT; // RL3
      exc_q <= cfg_excess; // RL10
      for (int i = 0; i < `EQS_NQ; i++) begin
        if (cfg_weight[i] >= `EQS_W_MIN && cfg_weight[i] <= `EQS_W_MAX) begin
          wt_q[i] <= cfg_weight[i]; // RL6
        end
        if (rate_ok(cfg_qshp[i])) qshp_q[i] <= cfg_qshp[i]; // RL8 RL9
        else qshp_q[i].en <= cfg_qshp[i].en;
      end
      if (rate_ok(cfg_pshp)) pshp_q <= cfg_pshp; // RL11 RL12 RL13
      else pshp_q.en <= cfg_pshp.en;
    end
  end

  // Token buckets and deficit counters.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `EQS_NQ; i++) begin
        qbkt_q[i] <= '0;
        dcnt_q[i] <= '0;
      end
      pbkt_q <= '0;
      rr_q <= '0;
      lock_q <= 1'b0;
      cur_q <= '0;
    end else begin
      for (int i = 0; i < `EQS_NQ; i++) begin
        qbkt_q[i] <= qshp_q[i].en ? refill(qbkt_q[i], credit(qshp_q[i]),
            (send && pick == 3'(i)) ? WORD_COST : 32'sd0) : 32'sd0; // RL19
      end
      pbkt_q <= pshp_q.en ? refill(pbkt_q, credit(pshp_q),
          send ? WORD_COST : 32'sd0) : 32'sd0; // RL14 RL19
      if (send) begin
        lock_q <= !q_last[pick];
        cur_q <= pick;
        if (q_last[pick]) rr_q <= 3'(pick + 3'd1); // RL4
      end
      if (elig_cr == '0) begin
        for (int i = 0; i < `EQS_NQ; i++) dcnt_q[i] <= {1'b0, wt_q[i]}; // RL4
      end else if (send && dcnt_q[pick] != 8'h00) begin
        dcnt_q[pick] <= dcnt_q[pick] - 8'h01;
      end
    end
  end

  // Status readout.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sts_mode <= EQS_STRICT;
      sts_weight <= '0;
      sts_percent <= '0;
      sts_qshp <= '0;
      sts_pshp <= '0;
      pct_q <= '0;
    end else begin
      sts_mode <= mode_q; // RL17
      for (int i = 0; i < `EQS_NQ; i++) begin
        pct_q[i] <= 7'((17'(wt_q[i]) * 17'd100) / 17'(wsum)); // RL7
        sts_weight[i] <= (mode_q == EQS_WT) ? wt_q[i] : 7'h00; // RL17
        sts_percent[i] <= (mode_q == EQS_WT) ? pct_q[i] : 7'h00; // RL7
        sts_qshp[i] <= qshp_q[i].en ? qshp_q[i] : '0; // RL16
      end
      sts_pshp <= pshp_q.en ? pshp_q : '0;
    end
  end
endmodule

// *** eqs_sched_sva.sv ***
// Port-level assertions for the egress scheduler.
// Assumes queue 7 is the highest priority and one word per take.
`timescale 1ns/1ps
module eqs_sched_sva
  import eqs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] q_valid,
  input wire logic [7:0] q_last,
  input wire logic [7:0] q_ready,
  input wire eqs_word_t tx_word,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic cfg_we,
  input wire logic cfg_weighted,
  input wire logic [7:0][6:0] cfg_weight,
  input wire eqs_shp_t cfg_pshp,
  input wire eqs_mode_t sts_mode,
  input wire logic [7:0][6:0] sts_weight,
  input wire logic [7:0][6:0] sts_percent,
  input wire eqs_shp_t [7:0] sts_qshp,
  input wire eqs_shp_t sts_pshp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] shp_on;
  always_comb for (int i = 0; i < 8; i++) shp_on[i] = sts_qshp[i].en;
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  a_ready_onehot: assert property ($onehot0(q_ready)) else $error("two queues taken");
  a_strict_order: assert property (sts_mode == EQS_STRICT && shp_on == 8'h00 && &q_last
    && q_ready != 8'h00 |-> (q_valid & ~((q_ready << 1) - 8'h01)) == 8'h00)
    else $error("lower queue served first");
  a_tx_hold: assert property (s_stall |=> tx_valid && $stable(tx_word))
    else $error("stalled word lost");
  a_mode_load: assert property (cfg_we |-> ##2
    sts_mode == ($past(cfg_weighted, 2) ? EQS_WT : EQS_STRICT))
    else $error("mode not loaded");
  a_pct_strict: assert property (sts_mode == EQS_STRICT && $past(sts_mode) == EQS_STRICT
    |-> sts_percent == '0) else $error("percent shown in strict");
  a_pshp_off: assert property (cfg_we && !cfg_pshp.en |-> ##2 sts_pshp == '0)
    else $error("disabled port shaper shown");
  a_wt_load: assert property (cfg_we && cfg_weighted && cfg_weight[0] inside {[7'h01:7'h64]}
    |-> ##2 sts_weight[0] == $past(cfg_weight[0], 2)) else $error("weight not loaded");
  a_wt_range: assert property (cfg_we && cfg_weighted && cfg_weight[0] == 7'h00
    |-> ##2 sts_weight[0] inside {[7'h01:7'h64]}) else $error("bad weight taken");
endmodule
bind eqs_sched eqs_sched_sva i_eqs_sched_sva (.core_clk(core_clk), .rst_n(rst_n),
  .q_valid(q_valid), .q_last(q_last), .q_ready(q_ready), .tx_word(tx_word),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .cfg_we(cfg_we), .cfg_weighted(cfg_weighted),
  .cfg_weight(cfg_weight), .cfg_pshp(cfg_pshp), .sts_mode(sts_mode), .sts_weight(sts_weight),
  .sts_percent(sts_percent), .sts_qshp(sts_qshp), .sts_pshp(sts_pshp));

// *** eqs_mac_model.sv ***
// Transmit MAC model that accepts words with a set stall pattern.
// Assumes the bench picks the stall length; zero means always ready.
`timescale 1ns/1ps
module eqs_mac_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] stall,
  output logic tx_ready
);
  logic [3:0] cnt_q;
  always @(negedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      tx_ready <= 1'b0;
    end else begin
      cnt_q <= (cnt_q >= stall) ? 4'h0 : cnt_q + 4'h1;
      tx_ready <= (cnt_q == 4'h0);
    end
  end
endmodule

// *** eqs_sched_tb.sv ***
// Self-checking bench for the egress scheduler with a MAC model.
// Assumes single-word frames and a 200 MHz core clock.
`timescale 1ns/1ps
module eqs_sched_tb;
  import eqs_pkg::*;
  logic core_clk, rst_n, tx_valid, tx_ready, cfg_we, cfg_weighted, chk_strict;
  logic [7:0] q_last, q_valid, q_ready, cfg_excess, tk, exp_take;
  logic [7:0][31:0] q_data;
  logic [7:0][6:0] cfg_weight, sts_weight, sts_percent;
  eqs_shp_t [7:0] cfg_qshp, sts_qshp;
  eqs_shp_t cfg_pshp, sts_pshp;
  eqs_word_t tx_word;
  eqs_mode_t sts_mode;
  logic [3:0] stall;
  logic [31:0] seed = 32'hc97f, exp_q[8][$];
  int n_errors, comparisons, cyc, left[8], w[8], sum, dur;
  eqs_sched i_eqs_sched (.core_clk(core_clk), .rst_n(rst_n), .q_data(q_data), .q_last(q_last),
    .q_valid(q_valid), .q_ready(q_ready), .tx_word(tx_word), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .cfg_we(cfg_we), .cfg_weighted(cfg_weighted), .cfg_weight(cfg_weight),
    .cfg_qshp(cfg_qshp), .cfg_excess(cfg_excess), .cfg_pshp(cfg_pshp), .sts_mode(sts_mode),
    .sts_weight(sts_weight), .sts_percent(sts_percent), .sts_qshp(sts_qshp), .sts_pshp(sts_pshp));
  eqs_mac_model i_eqs_mac_model (.core_clk(core_clk), .rst_n(rst_n), .stall(stall),
    .tx_ready(tx_ready));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic bit pend();
    pend = 0;
    for (int i = 0; i < 8; i++)
      if (left[i] > 0 || exp_q[i].size() > 0)
        pend = 1;
  endfunction
  task automatic chk(input logic [31:0] a, input logic [31:0] b, input string m);
    comparisons++;
    if (a !== b) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic drain(input string m);
    int t;
    t = 0;
    while (t < 20000 && pend()) begin
      @(negedge core_clk);
      t++;
    end
    dur = t;
    chk(t < 20000, 1, m);
    $display("test %s done", m);
  endtask
  task automatic cfg(input logic wt);
    cfg_weighted <= wt;
    cfg_we <= 1'b1;
    @(negedge core_clk);
    cfg_we <= 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  // Samples just before each rising edge, where the handshakes are settled.
  always begin
    @(negedge core_clk);
    #2.4;
    tk = q_valid & q_ready;
    exp_take = '0;
    for (int i = 0; i < 8; i++)
      if (q_valid[i])
        exp_take = 8'(1 << i);
    if (chk_strict && tk != '0)
      chk(tk, exp_take, "strict order");
    if (rst_n && tx_valid && tx_ready)
      chk(tx_word.data, exp_q[tx_word.queue].pop_front(), "word order");
    for (int i = 0; i < 8; i++)
      if (tk[i])
        exp_q[i].push_back(q_data[i]);
  end
  always @(negedge core_clk) begin
    cyc++;
    if (cyc > 90000) begin
      n_errors++;
      end_of_test();
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (tk[i]) begin
          left[i]--;
          q_data[i] <= rnd();
        end
        q_valid[i] <= left[i] > 0;
      end
    end
  end
  initial begin
    rst_n = 1'b0;
    {cfg_we, cfg_weighted, chk_strict, q_valid, cfg_excess, cfg_pshp, cfg_qshp, q_data} = '0;
    q_last = '1;
    stall = 4'h0;
    for (int i = 0; i < 8; i++) begin
      cfg_weight[i] = 7'h11;
      left[i] = 0;
    end
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    chk(sts_mode, EQS_STRICT, "reset mode");
    chk(sts_pshp, 0, "reset port shaper");
    chk(sts_qshp == '0, 1, "reset queue shapers");
    stall <= 4'h3;
    for (int i = 0; i < 8; i++)
      left[i] = 6;
    chk_strict = 1'b1;
    drain("strict");
    chk_strict = 1'b0;
    sum = 0;
    for (int i = 0; i < 8; i++) begin
      w[i] = rnd() % 100 + 1;
      sum += w[i];
      cfg_weight[i] = 7'(w[i]);
    end
    cfg(1'b1);
    for (int i = 0; i < 8; i++)
      chk(sts_percent[i], w[i] * 100 / sum, "percent");
    cfg_weight[0] = 7'h00;
    cfg_weight[1] = 7'h65;
    cfg(1'b1);
    chk(sts_weight[0], w[0], "low weight kept");
    chk(sts_weight[1], w[1], "high weight kept");
    stall <= 4'h7;
    for (int i = 0; i < 8; i++)
      left[i] = 4 + i;
    drain("weighted");
    for (int i = 0; i < 8; i++)
      cfg_qshp[i] = '{1'b1, i[0], i[0] ? 20'h0_0CE4 : 20'hF_4240};
    cfg_qshp[2].rate = 20'h0_0063;
    cfg_excess = 8'h01;
    cfg_pshp = '{1'b1, 1'b1, 20'h0_0CE4};
    cfg(1'b1);
    for (int i = 0; i < 8; i++)
      chk(sts_qshp[i], i == 2 ? 22'h20_01F4 : cfg_qshp[i], "queue shaper");
    chk(sts_pshp, cfg_pshp, "port shaper");
    stall <= 4'h0;
    for (int i = 0; i < 8; i++)
      left[i] = (i == 2) ? 0 : 4;
    drain("shaped");
    cfg_qshp = '0;
    cfg_pshp = '0;
    cfg(1'b0);
    chk(sts_qshp == '0, 1, "shapers off");
    cfg_pshp = '{1'b1, 1'b0, 20'h0_03E8};
    cfg(1'b0);
    left[0] = 4;
    drain("port rate");
    chk(dur >= 3 * 120, 1, "port rate cap");
    end_of_test();
  end
endmodule
